// ===== hw/icur_pkg.sv
/*
  shared constants and carrier types for the smart card receive path.
  assumes a single system clock domain; card clock, card reset and the
  card i/o line arrive as pins and are synchronised inside the block.
*/
package icur_pkg;

  // ==========================================================
  // fifo geometry
  localparam int FIFO_MAX = 8;            // entries, fixed depth in threshold mode
  localparam int PTR_W = 3;               // pointer width for FIFO_MAX
  localparam int CNT_W = 4;               // level width, holds 0..FIFO_MAX
  localparam int OB_DEPTH = 2;            // output buffer entries

  // ==========================================================
  // character frame, counted in half etu steps from the start edge
  localparam int DATA_BITS = 8;
  localparam logic [4:0] HS_START_CHK = 5'h01;  // 0.5 etu: start bit still low
  localparam logic [4:0] HS_FIRST_BIT = 5'h03;  // 1.5 etu: first data bit
  localparam logic [4:0] HS_PAR_BIT = 5'h13;    // 9.5 etu: parity bit
  localparam logic [4:0] HS_DONE = 5'h15;       // 10.5 etu: verdict, error signal start
  localparam logic [4:0] HS_ERR_END = 5'h17;    // 11.5 etu: error signal ends after 1.0 etu

  // ==========================================================
  // early answer timing in card clock cycles
  localparam logic [8:0] EA_IGNORE_END = 9'h0c8;   // 200
  localparam logic [8:0] EA_WIN_END = 9'h170;      // 368
  localparam logic [8:0] EA_ACCEPT_END = 9'h190;   // 400, counter saturates here
  localparam logic [5:0] EA_SAMPLE_LAST = 6'h2d;   // 46 cycle sampling period, last count
  localparam logic [8:0] EA_UNCERTAIN = 9'h020;    // 32 cycle blind zone at window end

  // ==========================================================
  // reset values
  localparam logic [2:0] RETRY_RESET = 3'h0;
  localparam logic [2:0] SYNC_IDLE = 3'h7;         // clk, io, rst idle high

  // synchroniser lanes
  localparam int LANE_CLK = 0;
  localparam int LANE_IO = 1;
  localparam int LANE_RST = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic direction_select;        // 1 transmit, 0 receive
    logic protocol_select;         // 0 selects t=0, 1 selects t=1
    logic inverse_parity_select;   // 1 expects inverse parity
    logic threshold_enable_lo;
    logic threshold_enable_hi;
    logic [2:0] fifo_length_field;
    logic [2:0] parity_retry_count;
  } icur_cfg_type;

  typedef struct packed {
    logic overrun;
    logic parity_error;
    logic early_answer;
  } icur_clr_type;

  typedef struct packed {
    logic buffer_full_flag;
    logic fifo_empty_flag;
    logic overrun_flag;
    logic parity_error_flag;
    logic early_answer_flag;
  } icur_status_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_FRAME = 3'b010,
    RX_ERRSIG = 3'b100
  } icur_rx_state_type;

endpackage : icur_pkg

// ===== hw/icur_rx.sv
/*
  receive path of an iso 7816 card uart: start detection, bit sampling, parity check with
  error signalling and retry counting, early answer detection, an eight entry receive fifo
  and a two entry output buffer. assumes card_clk, card_reset and card_io_in are asynchronous
  pins, the card clock is at least four times slower than clk, other controls are on clk.
*/
// How it works
// - error signals only under t=0 reception
// - even parity over eight data plus parity
// - bad parity, counter nonzero: low 10.5-11.5 etu
// - retry counter loaded from retry count field
// - counter zero and bad parity sets flag
// - good character reloads the retry counter
// - plain mode depth is length plus one
// - plain mode full, empty, overrun discards new
// - reads return the oldest unread character
// - entering receive clears the fifo
// - t=0 stores passing, t=1 stores all
// - threshold mode: depth eight, length is threshold
// - full flag and irq while level exceeds threshold
// - threshold length zero: plain depth and flags, no irq
// - depth eight full, overrun overwrites last character
// - depth zero full at one, overrun overwrites
// - early answer windows set flag and irq
// - too early ignored, late accepted unflagged
// - 46 cycle sampling, 32 cycle blind zone
// - inverse parity select flips the good parity
// - receive when direction is zero, empty flag
`timescale 1ns/1ps

module icur_rx #(
  parameter int ETU_CLKS = 16   // card clocks per etu, even
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // card side pins
  input wire logic card_clk,
  input wire logic card_reset,
  input wire logic card_io_in,
  output logic card_io_out_q,
  output logic card_io_oe_n_q,
  // control bits and flag clears
  input wire icur_pkg::icur_cfg_type cfg,
  input wire icur_pkg::icur_clr_type clr,
  // receive data stream towards the host
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  input wire logic rx_ready,
  // status and interrupt
  output icur_pkg::icur_status_type status_q,
  output logic irq_q
);
  // ==========================================================
  // helpers
  localparam logic [15:0] HALF_LAST = 16'(ETU_CLKS / 2 - 1);
  // threshold mode only counts when a usable threshold is set
  function automatic logic thr_active(input icur_pkg::icur_cfg_type c);
    return c.threshold_enable_lo & c.threshold_enable_hi & (c.fifo_length_field != 3'h0);
  endfunction : thr_active

  // storage limit of the fifo plus output buffer
  function automatic logic [3:0] cap_of(input icur_pkg::icur_cfg_type c);
    if (thr_active(c)) begin
      return 4'(icur_pkg::FIFO_MAX);
    end
    return {1'b0, c.fifo_length_field} + 4'h1;
  endfunction : cap_of

  // ==========================================================
  // pin synchronisers
  logic [2:0] s1_q;  // first stage, read only by s2_q
  logic [2:0] s2_q, s3_q;  // later stages, compared for agreement
  logic [2:0] lvl_q, lvl_d;  // accepted levels
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= icur_pkg::SYNC_IDLE;
      s2_q <= icur_pkg::SYNC_IDLE;
      s3_q <= icur_pkg::SYNC_IDLE;
      lvl_q <= icur_pkg::SYNC_IDLE;
    end else begin
      s1_q <= {card_reset, card_io_in, card_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
    end
  end

  logic cc_tick;   // one pulse per card clock rising edge
  logic io_fall;   // card line falling edge
  logic rst_edge;  // any change of card reset
  logic io_lvl, rst_lvl;  // settled line and card reset levels
  assign cc_tick = lvl_d[icur_pkg::LANE_CLK] & ~lvl_q[icur_pkg::LANE_CLK];
  assign io_fall = ~lvl_d[icur_pkg::LANE_IO] & lvl_q[icur_pkg::LANE_IO];
  assign rst_edge = lvl_d[icur_pkg::LANE_RST] ^ lvl_q[icur_pkg::LANE_RST];
  assign io_lvl = lvl_q[icur_pkg::LANE_IO];
  assign rst_lvl = lvl_q[icur_pkg::LANE_RST];
  // ==========================================================
  // early answer detection
  logic [8:0] ea_cnt_q;   // card clocks since last card reset change
  logic [5:0] ea_per_q;   // position inside a 46 cycle sampling period
  logic ea_hit;           // start bit seen in a flagged window
  logic ea_block;         // start bits too early to be accepted

  // both counters restart on every card reset change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_cnt_q <= icur_pkg::EA_ACCEPT_END;
      ea_per_q <= 6'h00;
    end else if (rst_edge) begin
      ea_cnt_q <= 9'h000;
      ea_per_q <= 6'h00;
    end else if (cc_tick) begin
      if (ea_cnt_q != icur_pkg::EA_ACCEPT_END) begin
        ea_cnt_q <= ea_cnt_q + 9'h001;
      end
      ea_per_q <= (ea_per_q == icur_pkg::EA_SAMPLE_LAST) ? 6'h00 : ea_per_q + 6'h01;
    end
  end

  // the line is looked at once per sampling period; the last 32 cycles
  // of each window are blind, so a late start there goes unflagged
  always_comb begin
    ea_hit = 1'b0;
    if (cc_tick && ea_per_q == icur_pkg::EA_SAMPLE_LAST && !io_lvl
        && !cfg.direction_select
        && ea_cnt_q < icur_pkg::EA_WIN_END - icur_pkg::EA_UNCERTAIN) begin
      ea_hit = rst_lvl || ea_cnt_q >= icur_pkg::EA_IGNORE_END;
    end
  end
  assign ea_block = !rst_lvl && ea_cnt_q < icur_pkg::EA_IGNORE_END;
  // ==========================================================
  // character receiver
  icur_pkg::icur_rx_state_type st_q;
  logic [15:0] hc_q;        // card clocks inside the current half etu
  logic [4:0] hs_q;         // half etu steps since the start edge
  logic [8:0] sh_q;         // data bits then parity, lsb first
  logic accept_q;           // this character may be stored
  logic [2:0] retry_q;      // consecutive parity error counter
  logic [2:0] retry_cfg_q;  // last programmed retry count, to see rewrites
  logic wr_q;               // one cycle pulse: store wr_dat_q
  logic [7:0] wr_dat_q;
  logic pe_set_q;           // one cycle pulse: parity error flag
  logic step, par_ok;       // half etu boundary, parity verdict
  assign step = cc_tick && hc_q == HALF_LAST;
  // even parity over nine bits; inverse select makes odd the good one
  assign par_ok = (^sh_q) == cfg.inverse_parity_select;
  // frame sequencer; only runs while the direction is receive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= icur_pkg::RX_IDLE;
      hc_q <= 16'h0000;
      hs_q <= 5'h00;
      sh_q <= 9'h000;
      accept_q <= 1'b0;
    end else if (cfg.direction_select) begin
      st_q <= icur_pkg::RX_IDLE;
    end else begin
      if (cc_tick) begin
        hc_q <= step ? 16'h0000 : hc_q + 16'h0001;
      end
      if (step) begin
        hs_q <= hs_q + 5'h01;
      end
      unique case (st_q)
        icur_pkg::RX_IDLE: begin
          if (io_fall) begin
            st_q <= icur_pkg::RX_FRAME;
            hc_q <= 16'h0000;
            hs_q <= 5'h00;
            accept_q <= !ea_block;
          end
        end
        icur_pkg::RX_FRAME: begin
          if (step) begin
            // sample in the middle of each bit
            if (hs_q + 5'h01 == icur_pkg::HS_START_CHK && io_lvl) begin
              st_q <= icur_pkg::RX_IDLE;  // glitch, not a start bit
            end else if (hs_q + 5'h01 >= icur_pkg::HS_FIRST_BIT
                         && hs_q + 5'h01 <= icur_pkg::HS_PAR_BIT && !hs_q[0]) begin
              sh_q <= {io_lvl, sh_q[8:1]};
            end else if (hs_q + 5'h01 == icur_pkg::HS_DONE) begin
              // error signal under t=0 while retries remain
              if (!cfg.protocol_select && !par_ok && retry_q != 3'h0) begin
                st_q <= icur_pkg::RX_ERRSIG;
              end else begin
                st_q <= icur_pkg::RX_IDLE;
              end
            end
          end
        end
        icur_pkg::RX_ERRSIG: begin
          if (step && hs_q + 5'h01 == icur_pkg::HS_ERR_END) begin
            st_q <= icur_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
  logic verdict;  // the 10.5 etu point of a character
  assign verdict = st_q == icur_pkg::RX_FRAME && step && hs_q + 5'h01 == icur_pkg::HS_DONE
                   && !cfg.direction_select;
  // retry counting and parity flag pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_q <= icur_pkg::RETRY_RESET;
      retry_cfg_q <= icur_pkg::RETRY_RESET;
      pe_set_q <= 1'b0;
    end else begin
      retry_cfg_q <= cfg.parity_retry_count;
      pe_set_q <= 1'b0;
      if (retry_cfg_q != cfg.parity_retry_count) begin
        retry_q <= cfg.parity_retry_count;
      end else if (verdict && par_ok) begin
        retry_q <= cfg.parity_retry_count;
      end else if (verdict) begin
        if (cfg.protocol_select || retry_q == 3'h0) begin
          pe_set_q <= 1'b1;
        end else begin
          retry_q <= retry_q - 3'h1;
        end
      end
    end
  end

  // what reaches the fifo
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      wr_dat_q <= 8'h00;
    end else begin
      wr_q <= verdict && accept_q && (cfg.protocol_select || par_ok);
      wr_dat_q <= sh_q[7:0];
    end
  end

  // open drain card line: pulled low only during the error signal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_io_out_q <= 1'b0;
      card_io_oe_n_q <= 1'b1;
    end else begin
      card_io_out_q <= 1'b0;
      card_io_oe_n_q <= !(st_q == icur_pkg::RX_ERRSIG && !cfg.direction_select);
    end
  end
  // ==========================================================
  // receive fifo and two entry output buffer
  logic [7:0] mem_q [icur_pkg::FIFO_MAX];
  logic [icur_pkg::PTR_W-1:0] wp_q, rp_q;  // write and read pointers
  logic [3:0] fcnt_q;    // entries in mem_q
  logic [1:0] obc_q;     // entries in the output buffer
  logic [7:0] ob1_q;     // second output buffer entry; rx_data_q is the first
  logic dir_prev_q;
  logic enter_rx, pop, move, push, ovw;  // per cycle fifo events
  logic [3:0] total, cap;  // entries held and storage limit
  logic [1:0] obn;  // output buffer entries after a pop
  assign enter_rx = dir_prev_q && !cfg.direction_select;
  assign pop = rx_valid_q && rx_ready;
  assign total = fcnt_q + {2'b00, obc_q};
  assign cap = cap_of(cfg);
  assign push = wr_q && (total - {3'b000, pop}) < cap;
  // in plain mode the newcomer is lost, in threshold mode it overwrites
  assign ovw = wr_q && !push && cfg.threshold_enable_lo && cfg.threshold_enable_hi;
  assign obn = obc_q - {1'b0, pop};
  assign move = fcnt_q != 4'h0 && obn != 2'h2;

  // storage; in plain mode a stall on rx_ready leaves words in place until taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      fcnt_q <= 4'h0;
      obc_q <= 2'h0;
      ob1_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      dir_prev_q <= 1'b0;
    end else begin
      dir_prev_q <= cfg.direction_select;
      if (enter_rx) begin
        wp_q <= '0;
        rp_q <= '0;
        fcnt_q <= 4'h0;
        obc_q <= 2'h0;
        rx_valid_q <= 1'b0;
      end else begin
        if (push) begin
          mem_q[wp_q] <= wr_dat_q;
          wp_q <= wp_q + 1'b1;
        end else if (ovw && fcnt_q != 4'h0) begin
          mem_q[wp_q - 1'b1] <= wr_dat_q;
        end else if (ovw && obc_q == 2'h2) begin
          ob1_q <= wr_dat_q;
        end else if (ovw) begin
          rx_data_q <= wr_dat_q;
        end
        if (pop) begin
          rx_data_q <= ob1_q;
        end
        if (move) begin
          rp_q <= rp_q + 1'b1;
          if (obn == 2'h0) begin
            rx_data_q <= mem_q[rp_q];
          end else begin
            ob1_q <= mem_q[rp_q];
          end
        end
        fcnt_q <= fcnt_q + {3'b000, push} - {3'b000, move};
        obc_q <= obn + {1'b0, move};
        rx_valid_q <= (obn + {1'b0, move}) != 2'h0;
      end
    end
  end
  // ==========================================================
  // status flags and interrupt
  logic full_now, ovr_set;  // level at limit or above threshold, arrival with no room
  assign full_now = thr_active(cfg)
                    ? total > {1'b0, cfg.fifo_length_field}
                    : total >= cap;
  assign ovr_set = wr_q && !push;
  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      status_q.fifo_empty_flag <= 1'b1;
    end else begin
      status_q.buffer_full_flag <= full_now && !enter_rx;
      status_q.fifo_empty_flag <= enter_rx || total == 4'h0;
      if (enter_rx) begin
        status_q.overrun_flag <= 1'b0;
      end else if (ovr_set) begin
        status_q.overrun_flag <= 1'b1;
      end else if (clr.overrun) begin
        status_q.overrun_flag <= 1'b0;
      end
      if (pe_set_q) begin
        status_q.parity_error_flag <= 1'b1;
      end else if (clr.parity_error) begin
        status_q.parity_error_flag <= 1'b0;
      end
      if (ea_hit) begin
        status_q.early_answer_flag <= 1'b1;
      end else if (clr.early_answer) begin
        status_q.early_answer_flag <= 1'b0;
      end
    end
  end

  // interrupt follows early answer and the threshold crossing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= status_q.early_answer_flag || ea_hit
               || (thr_active(cfg) && full_now && !enter_rx);
    end
  end

endmodule : icur_rx

// ===== bench/icur_rx_properties.sv
/*
  port checker for the card receive path, bound into icur_rx.
  assumes clk runs eight times faster than the card clock.
*/
`timescale 1ns/1ps

module icur_rx_properties #(
  parameter int ETU_CLKS = 16  // card clocks per etu, as in the design
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic card_io_out_q,
  input wire logic card_io_oe_n_q,
  input wire icur_pkg::icur_cfg_type cfg,
  input wire logic [7:0] rx_data_q,
  input wire logic rx_valid_q,
  input wire logic rx_ready,
  input wire icur_pkg::icur_status_type status_q,
  input wire logic irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // helpers
  logic [8:0] low_q;  // cycles of the current error pulse
  logic both;  // both threshold enables set
  logic thr;  // threshold mode proper, length nonzero
  assign both = cfg.threshold_enable_lo & cfg.threshold_enable_hi;
  assign thr = both & (cfg.fifo_length_field != 3'h0);

  // count the pulse length, 9 bits cover a whole etu of clk cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 9'h000;
    end else if (!card_io_oe_n_q) begin
      low_q <= low_q + 9'h001;
    end else begin
      low_q <= 9'h000;
    end
  end

  // a settled receive mode and a host that stalls
  sequence s_rx_mode;
    !cfg.direction_select [*3];
  endsequence
  sequence s_stall;
    rx_valid_q && !rx_ready && !both;
  endsequence

  // ==========================================================
  // properties
  AST_OUT_LOW: assert property (card_io_out_q == 1'b0)
    else $error("io output value not low");
  AST_ERR_LEN: assert property (
    $rose(card_io_oe_n_q) |-> low_q >= ETU_CLKS * 8 - 8 && low_q <= ETU_CLKS * 8 + 8)
    else $error("error signal length wrong");
  AST_T1_QUIET: assert property (
    cfg.protocol_select && $past(cfg.protocol_select) |-> card_io_oe_n_q)
    else $error("error signal under t1");
  AST_HOLD: assert property (s_rx_mode ##0 s_stall |=> rx_valid_q && $stable(rx_data_q))
    else $error("word lost during stall");
  AST_FULL_NOT_EMPTY: assert property (
    status_q.buffer_full_flag |-> !status_q.fifo_empty_flag)
    else $error("full and empty together");
  AST_EA_IRQ: assert property (status_q.early_answer_flag [*2] |-> irq_q)
    else $error("early answer without irq");
  AST_PLAIN_NO_IRQ: assert property ((!status_q.early_answer_flag && !thr) [*2] |-> !irq_q)
    else $error("irq without cause");
  AST_THR_IRQ: assert property ((thr && status_q.buffer_full_flag) [*2] |-> irq_q)
    else $error("threshold full without irq");
endmodule : icur_rx_properties

bind icur_rx icur_rx_properties #(.ETU_CLKS(ETU_CLKS)) u_icur_rx_properties (
  .clk(clk), .rst_n(rst_n), .card_io_out_q(card_io_out_q), .card_io_oe_n_q(card_io_oe_n_q),
  .cfg(cfg), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_ready(rx_ready),
  .status_q(status_q), .irq_q(irq_q));

// ===== bench/icur_card_model.sv
/*
  behavioural card on the i/o line: sends characters, direct convention.
  assumes a pull-up on the line, so a released driver reads as high.
*/
`timescale 1ns/1ps

module icur_card_model #(
  parameter int ETU_CLKS = 16
) (
  // card clock and the shared line
  input wire logic card_clk,
  input wire logic io_line,
  // open drain drive, 1 means released
  output logic card_drive
);
  initial card_drive = 1'b1;

  // bits change on falling card edges, clear of the rising sample edges
  task automatic send(input logic [7:0] d, input logic p, output logic err);
    logic [9:0] fr;
    fr = {p, d, 1'b0};  // start, data lsb first, parity
    for (int i = 0; i < 10; i++) begin
      @(negedge card_clk);
      card_drive = fr[i];
      repeat (ETU_CLKS - 1) @(negedge card_clk);
    end
    @(negedge card_clk);
    card_drive = 1'b1;
    // look for the reader's error pulse in the middle of its slot
    repeat (ETU_CLKS) @(negedge card_clk);
    err = !io_line;
    // guard so the next start follows the end of any pulse
    repeat (ETU_CLKS * 2) @(negedge card_clk);
  endtask : send
endmodule : icur_card_model

// ===== bench/test_icur_rx.sv
/*
  self-checking bench for icur_rx with a card model on the i/o line.
  assumes 25 MHz clk and a free running 320 ns card clock.
*/
`timescale 1ns/1ps

module test_icur_rx;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_n, card_clk, card_reset, rx_ready, rx_valid_q, irq_q;
  logic io_out, oe_n, drive;
  wire logic io;  // open drain line with pull-up
  logic [7:0] rx_data_q;
  icur_pkg::icur_cfg_type cfg;
  icur_pkg::icur_clr_type clr;
  icur_pkg::icur_status_type st;
  int errors = 0;
  int checked = 0;
  int n;
  logic [7:0] d [0:8];

  assign io = oe_n ? drive : 1'b0;
  always #20 clk = ~clk;
  initial begin
    card_clk = 1'b0;
    #7;
    forever #160 card_clk = ~card_clk;
  end

  icur_rx u_icur_rx (.clk(clk), .rst_n(rst_n), .card_clk(card_clk), .card_reset(card_reset),
    .card_io_in(io), .card_io_out_q(io_out), .card_io_oe_n_q(oe_n), .cfg(cfg), .clr(clr),
    .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_ready(rx_ready), .status_q(st),
    .irq_q(irq_q));
  icur_card_model u_icur_card_model (.card_clk(card_clk), .io_line(io), .card_drive(drive));

  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic chk1(input string s, input logic e, input logic g);
    chk(s, {7'h00, e}, {7'h00, g});
  endtask : chk1

  // one character, good or bad parity, and whether a pulse is due
  task automatic send(input logic [7:0] v, input logic good, input logic sig);
    logic e;
    u_icur_card_model.send(v, good ? ^v : ~^v, e);
    @(negedge clk);  // later inputs change on the falling clk edge
    chk1("error_signal", sig, e);
  endtask : send

  // one read of the oldest word
  task automatic pop(input logic [7:0] e);
    int t;
    t = 0;
    @(negedge clk);
    while (rx_valid_q !== 1'b1 && t < 50) begin
      @(negedge clk);
      t++;
    end
    chk1("rx_valid", 1'b1, rx_valid_q);
    chk("rx_data", e, rx_data_q);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    // flags follow the read one edge later
    @(negedge clk);
  endtask : pop

  // back to transmit and into receive again, which empties the fifo
  task automatic restart();
    @(negedge clk);
    cfg.direction_select = 1'b1;
    repeat (2) @(negedge clk);
    cfg.direction_select = 1'b0;
    repeat (4) @(negedge clk);
  endtask : restart

  task automatic clear_flags();
    @(negedge clk);
    clr = 3'h7;
    @(negedge clk);
    clr = 3'h0;
  endtask : clear_flags

  // ==========================================================
  // watchdog, the run needs under 3 ms
  initial begin
    #3800000;
    errors++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    cfg = '0;
    clr = 3'h0;
    rx_ready = 1'b0;
    card_reset = 1'b1;
    void'($urandom(32'h9101));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk1("empty", 1'b1, st.fifo_empty_flag);
    chk1("oe_n", 1'b1, oe_n);
    // early answer windows, all-zero character keeps the line low long
    repeat (4) @(negedge clk);
    card_reset = 1'b0;
    repeat (40) @(posedge card_clk);
    send(8'h00, 1'b1, 1'b0);
    chk1("ea_early", 1'b0, st.early_answer_flag);
    chk1("empty_early", 1'b1, st.fifo_empty_flag);
    repeat (10) @(posedge card_clk);
    send(8'h00, 1'b1, 1'b0);
    chk1("ea_low", 1'b1, st.early_answer_flag);
    pop(8'h00);
    clear_flags();
    card_reset = 1'b1;
    repeat (40) @(posedge card_clk);
    send(8'h00, 1'b1, 1'b0);
    chk1("ea_high", 1'b1, st.early_answer_flag);
    chk1("irq_ea", 1'b1, irq_q);
    pop(8'h00);
    clear_flags();
    repeat (420) @(posedge card_clk);
    @(negedge clk);
    // plain fifo: depth length plus one, then overrun drops the newcomer
    for (int k = 0; k < 3; k++) begin
      n = k ? int'($urandom % 4) : 0;
      cfg.fifo_length_field = n[2:0];
      restart();
      for (int i = 0; i <= n + 1; i++) begin
        d[i] = 8'($urandom);
        send(d[i], 1'b1, 1'b0);
        chk1("full", i >= n, st.buffer_full_flag);
        chk1("overrun", i > n, st.overrun_flag);
      end
      for (int i = 0; i <= n; i++) pop(d[i]);
      chk1("empty_after", 1'b1, st.fifo_empty_flag);
      restart();
      chk1("overrun_cleared", 1'b0, st.overrun_flag);
    end
    // retry counting under t=0
    cfg.fifo_length_field = 3'h7;
    cfg.parity_retry_count = 3'h1;
    restart();
    send(8'h5a, 1'b0, 1'b1);
    send(8'h3c, 1'b1, 1'b0);
    send(8'h81, 1'b0, 1'b1);
    chk1("pe_retry", 1'b0, st.parity_error_flag);
    send(8'h81, 1'b0, 1'b0);
    chk1("pe_set", 1'b1, st.parity_error_flag);
    pop(8'h3c);
    chk1("bad_dropped", 1'b1, st.fifo_empty_flag);
    clear_flags();
    // inverse parity expected
    cfg.inverse_parity_select = 1'b1;
    cfg.parity_retry_count = 3'h2;
    send(8'h77, 1'b0, 1'b0);
    send(8'h12, 1'b1, 1'b1);
    pop(8'h77);
    chk1("inv_dropped", 1'b1, st.fifo_empty_flag);
    cfg.inverse_parity_select = 1'b0;
    // t=1 stores everything, flags at once, never pulls the line
    cfg.protocol_select = 1'b1;
    send(8'he4, 1'b0, 1'b0);
    chk1("pe_t1", 1'b1, st.parity_error_flag);
    pop(8'he4);
    clear_flags();
    cfg.protocol_select = 1'b0;
    // threshold mode at two, eight entries inside
    cfg.threshold_enable_lo = 1'b1;
    cfg.threshold_enable_hi = 1'b1;
    cfg.fifo_length_field = 3'h2;
    restart();
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      send(d[i], 1'b1, 1'b0);
      chk1("thr_full", i >= 2, st.buffer_full_flag);
      chk1("thr_irq", i >= 2, irq_q);
    end
    pop(d[0]);
    repeat (3) @(negedge clk);
    chk1("thr_full_off", 1'b0, st.buffer_full_flag);
    chk1("thr_irq_off", 1'b0, irq_q);
    pop(d[1]);
    pop(d[2]);
    // threshold seven: eight entries, the ninth overwrites the eighth
    cfg.fifo_length_field = 3'h7;
    restart();
    for (int i = 0; i < 9; i++) begin
      d[i] = 8'($urandom);
      send(d[i], 1'b1, 1'b0);
      chk1("d8_full", i >= 7, st.buffer_full_flag);
      chk1("d8_overrun", i > 7, st.overrun_flag);
    end
    for (int i = 0; i < 7; i++) pop(d[i]);
    pop(d[8]);
    // threshold of zero: one entry, overrun overwrites
    cfg.fifo_length_field = 3'h0;
    restart();
    send(8'ha5, 1'b1, 1'b0);
    chk1("z_full", 1'b1, st.buffer_full_flag);
    send(8'h42, 1'b1, 1'b0);
    chk1("z_overrun", 1'b1, st.overrun_flag);
    pop(8'h42);
    stop_test();
  end
endmodule : test_icur_rx
